// file: dv/ocs_ctrl.sv
// Controller model: link state, mode and command levels.
// Assumes knobs change just after a rising edge of aclk.
`timescale 1ns/100ps
`default_nettype none
module ocs_ctrl (
    input wire logic aclk,
    input wire logic [9:0] knob,
    output var logic [9:0] drv = 10'h200
);
    // Knob is link lost, program mode, command; registered like a real link
    always @(posedge aclk) drv <= {!knob[9], knob[8:0]};
endmodule
`default_nettype wire

// file: dv/ocs_top_tb.sv
// Bench: AXI4-Lite steps, read results checked from a queue.
// Assumes ocs_ctrl stands in for the controller.
`timescale 1ns/100ps
`default_nettype none
module ocs_top_tb;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, pg = 0;
    logic awr, wrd, bv, arr, rv;
    logic [31:0] aa = 0, wd = 0, rdat;
    logic [1:0] rresp, bresp;
    logic [9:0] kn = 0, dv;
    logic [7:0] cm, bd = 0, ol;
    logic [3:0] dg = 0;
    logic [4:0] h = 0;
    logic [33:0] q[$], ec, ep, e;
    int miscompares = 0, n_compared = 0;
    always #2.5 aclk = ~aclk; // 200 MHz
    ocs_ctrl ctl (.aclk(aclk), .knob(kn), .drv(dv));
    ocs_top #(.TICK_CYCLES(10)) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aa),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(aa), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .link_ok(dv[9]), .prog_mode(dv[8]),
        .cmd_level(dv[7:0]), .diag_cond(dg), .prognostic_hit(pg), .ch_bad_cond(bd),
        .ch_doubt_cond(~bd), .out_level(ol));
    task results;
        if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [33:0] e, input logic [33:0] g);
        n_compared++;
        if (g !== e) $display("ERROR rdata expected %h seen %h", e, g);
        if (g !== e) miscompares++;
    endtask
    task chk_b(input logic [1:0] e, input logic [1:0] g);
        n_compared++;
        if (g !== e) $display("ERROR bresp expected %h seen %h", e, g);
        if (g !== e) miscompares++;
    endtask
    task chk_o(input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) $display("ERROR out_level expected %h seen %h", e, g);
        if (g !== e) miscompares++;
    endtask
    task wt(input int b);
        int n;
        for (n = 0; n < 50 && !h[b]; n++) @(posedge aclk);
        if (!h[b]) begin
            miscompares++;
            results();
        end else @(posedge aclk);
    endtask
    // Set link and diag inputs, wait, then one access; the extra edge avoids races
    task st(input int m, input int c, input int n, input int w, input logic [7:0] a,
            input logic [33:0] d);
        kn <= {m[1:0], m[2] ? ~cm : cm};
        {dg, pg} <= c[4:0];
        repeat (n) @(posedge aclk);
        aa <= {24'h0, a};
        wd <= d[31:0];
        {awv, wv, br} <= {3{w[0]}};
        {arv, rr} <= {2{!w[0]}};
        q.push_back(d);
        wt(w ? 2 : 0);
    endtask
    // Handshakes sampled mid-cycle; every answer checked against the oldest note
    always @(negedge aclk) begin
        h = {awv && awr, wv && wrd, br && bv, arv && arr, rr && rv};
        if (h[0] || h[2]) e = q.pop_front();
        if (h[0]) chk(e, {rresp, rdat});
        if (h[0] && aa[7:0] == 8'h20) chk_o(e[7:0], ol);
        if (h[2]) chk_b(e[33:32], bresp);
    end
    // Each channel released at the edge that takes it
    always @(posedge aclk) if (|h) {awv, wv, br, arv, rr} <= {awv, wv, br, arv, rr} & ~h;
    initial begin
        void'($urandom(32'h1bd8));
        cm = 8'($urandom());
        ec = {26'h0, cm};
        ep = {26'h0, ~cm[7:4], 4'h5};
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        bd <= 8'($urandom());
        st(0, 0, 0, 0, 8'h3c, {2'b10, 32'h0});
        st(0, 0, 0, 1, 8'h3c, {2'b10, 32'h0});
        st(0, 0, 2, 0, 8'h20, ec);
        st(0, 0, 0, 1, 8'h00, 34'hff);
        st(0, 0, 0, 1, 8'h04, 34'ha5);
        st(0, 0, 0, 1, 8'h10, 34'h3c);
        st(0, 0, 0, 1, 8'h18, 34'h2);
        st(2, 0, 4, 0, 8'h1c, 34'h2);
        st(2, 0, 0, 0, 8'h20, 34'ha5);
        st(2, 0, 30, 0, 8'h20, 34'h3c);
        st(0, 0, 0, 1, 8'h00, 34'h0);
        st(6, 0, 4, 0, 8'h20, ec);
        st(4, 0, 0, 1, 8'h08, 34'hf);
        st(4, 0, 0, 1, 8'h0c, 34'h5);
        st(5, 0, 4, 0, 8'h20, ep);
        // Waits past the hold time so a wrong entry into fault mode shows the final level
        st(7, 0, 30, 0, 8'h20, ep);
        st(7, 0, 0, 1, 8'h14, 34'hff);
        st(7, 0, 30, 0, 8'h20, 34'h3c);
        st(0, 2, 3, 0, 8'h24, {26'h0, bd});
        st(0, 0, 3, 0, 8'h1c, 34'h201);
        st(0, 5, 3, 0, 8'h28, {26'h0, ~bd});
        st(0, 5, 3, 0, 8'h1c, 34'h305);
        // Toggle one condition until the event count wraps past 255
        repeat (253) begin
            dg <= dg ^ 4'h8;
            @(posedge aclk);
        end
        st(0, 21, 3, 0, 8'h1c, 34'h105);
        bd <= 8'h0;
        st(0, 5, 3, 0, 8'h24, 34'h0);
        st(0, 5, 0, 1, 8'h18, 34'h0);
        st(6, 5, 30, 0, 8'h20, ec);
        results();
    end
endmodule
`default_nettype wire

// file: src/ocs_chan.sv
// One output channel: safe-state machine and its output level.
// Assumes tick pulses once a second, aligned to the loss of the link.
`timescale 1ns/100ps
`default_nettype none
module ocs_chan (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic link_ok,
    input wire logic prog_mode,
    input wire logic cmd_level,
    input wire logic tick,
    input wire logic [7:0] hold_time,
    input wire ocs_pkg::ocs_cfg_t cfg,
    output logic out_level
);
    ocs_pkg::ocs_state_t state_reg, state_next;
    logic [7:0] secs_reg;
    logic out_reg, out_next;
    logic expired;

    // zero never expires
    // Compare with >= so that lowering the setting mid-fault still ends it
    assign expired = (hold_time != ocs_pkg::HOLD_RESET) && (secs_reg >= hold_time);
    assign out_level = out_reg;

    // ==========================================================
    // State selection
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ocs_pkg::OCS_CH_RUN: begin
                if (!link_ok) begin
                    state_next = ocs_pkg::OCS_CH_FAULT;
                end else if (prog_mode) begin
                    state_next = ocs_pkg::OCS_CH_PROG;
                end
            end
            ocs_pkg::OCS_CH_PROG: begin
                if (!link_ok) begin
                    if (cfg.prog_to_fault) begin
                        state_next = ocs_pkg::OCS_CH_FAULT;
                    end
                end else if (!prog_mode) begin
                    state_next = ocs_pkg::OCS_CH_RUN;
                end
            end
            ocs_pkg::OCS_CH_FAULT: begin
                if (link_ok) begin
                    state_next = prog_mode ? ocs_pkg::OCS_CH_PROG : ocs_pkg::OCS_CH_RUN;
                end else if (expired) begin
                    state_next = ocs_pkg::OCS_CH_FINAL;
                end
            end
            ocs_pkg::OCS_CH_FINAL: begin
                if (link_ok) begin
                    state_next = prog_mode ? ocs_pkg::OCS_CH_PROG : ocs_pkg::OCS_CH_RUN;
                end
            end
            default: state_next = ocs_pkg::OCS_CH_RUN;
        endcase
    end

    // ==========================================================
    // Output level, taken from the present state one cycle later
    always_comb begin
        case (state_reg)
            // follow the command; hold on link loss
            // A command arriving with the link loss is not trusted, so it is not taken
            ocs_pkg::OCS_CH_RUN: out_next = (link_ok && !prog_mode) ? cmd_level : out_reg;
            ocs_pkg::OCS_CH_PROG: out_next = cfg.prog_action ? cfg.prog_level : out_reg;
            ocs_pkg::OCS_CH_FAULT: out_next = cfg.fault_action ? cfg.fault_level : out_reg;
            ocs_pkg::OCS_CH_FINAL: out_next = cfg.post_level;
            default: out_next = out_reg;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ocs_pkg::OCS_CH_RUN;
            out_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            out_reg <= out_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || link_ok || state_reg != ocs_pkg::OCS_CH_FAULT) begin
            secs_reg <= 8'h00;
        end else if (tick && secs_reg != ocs_pkg::SECS_MAX) begin
            secs_reg <= secs_reg + 8'h01;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    fault_hold_a: assert property (
        state_reg == ocs_pkg::OCS_CH_FAULT && !cfg.fault_action |=> $stable(out_reg))
        else $error("fault hold changed output");
    fault_level_a: assert property (
        state_reg == ocs_pkg::OCS_CH_FAULT && cfg.fault_action
        |=> out_reg == $past(cfg.fault_level))
        else $error("fault level not driven");
    prog_hold_a: assert property (
        state_reg == ocs_pkg::OCS_CH_PROG && !cfg.prog_action |=> $stable(out_reg))
        else $error("program hold changed output");
    prog_level_a: assert property (
        state_reg == ocs_pkg::OCS_CH_PROG && cfg.prog_action
        |=> out_reg == $past(cfg.prog_level))
        else $error("program level not driven");
    final_level_a: assert property (
        state_reg == ocs_pkg::OCS_CH_FINAL |=> out_reg == $past(cfg.post_level))
        else $error("final level not driven");
    hold_forever_a: assert property (
        state_reg == ocs_pkg::OCS_CH_FAULT && hold_time == 8'h00
        |=> state_reg != ocs_pkg::OCS_CH_FINAL)
        else $error("zero hold time expired");
    prog_stay_a: assert property (
        state_reg == ocs_pkg::OCS_CH_PROG && !link_ok && !cfg.prog_to_fault
        |=> state_reg == ocs_pkg::OCS_CH_PROG)
        else $error("left program mode on fault");
    timer_clear_a: assert property (
        link_ok |=> secs_reg == 8'h00)
        else $error("hold timer not cleared");
    run_follow_a: assert property (
        aresetn && state_reg == ocs_pkg::OCS_CH_RUN && link_ok && !prog_mode
        |=> out_reg == $past(cmd_level))
        else $error("run output not following command");
    run_hold_a: assert property (
        state_reg == ocs_pkg::OCS_CH_RUN && !link_ok |=> $stable(out_reg))
        else $error("run output moved on link loss");

endmodule
`default_nettype wire

// file: src/ocs_pkg.sv
// Shared constants and types for the output channel safe-state block.
// Assumes a single 200 MHz clock and 32-bit AXI4-Lite register access.
package ocs_pkg;

    // ==========================================================
    // Sizes
    localparam int NUM_CH = 8;
    localparam int NUM_DIAG = 4;
    localparam int ADDR_W = 8;
    localparam int PRESC_W = 28;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_FAULT_ACT = 8'h00;
    localparam logic [7:0] OFS_FAULT_LVL = 8'h04;
    localparam logic [7:0] OFS_PROG_ACT = 8'h08;
    localparam logic [7:0] OFS_PROG_LVL = 8'h0c;
    localparam logic [7:0] OFS_POST_LVL = 8'h10;
    localparam logic [7:0] OFS_PROG_FLT = 8'h14;
    localparam logic [7:0] OFS_HOLD_TIME = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_CH_VALUE = 8'h20;
    localparam logic [7:0] OFS_CH_BAD = 8'h24;
    localparam logic [7:0] OFS_CH_DOUBT = 8'h28;

    // ==========================================================
    // Field positions and values after reset
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_LOST_BIT = 1;
    localparam int STAT_DIAG_BIT = 2;
    localparam int STAT_CNT_LSB = 8;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] HOLD_RESET = 8'h00;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CNT_WRAP = 8'h01;
    localparam logic [7:0] SECS_MAX = 8'hff;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ==========================================================
    // Timing: one-second time base for the fault hold timer
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned TICK_S = 1;
    localparam int unsigned TICK_CYCLES = TICK_S * CLK_HZ;

    // ==========================================================
    // Types
    typedef logic [PRESC_W-1:0] ocs_presc_t;

    typedef enum logic [1:0] {
        OCS_CH_RUN = 2'b00,
        OCS_CH_PROG = 2'b01,
        OCS_CH_FAULT = 2'b10,
        OCS_CH_FINAL = 2'b11
    } ocs_state_t;

    typedef struct packed {
        logic fault_action;
        logic fault_level;
        logic prog_action;
        logic prog_level;
        logic post_level;
        logic prog_to_fault;
    } ocs_cfg_t;

endpackage

// file: src/ocs_top.sv
// Output channel safe-state block: AXI4-Lite registers, time base,
// diagnostic reporting and one safe-state machine per channel.
// Assumes link, mode and condition inputs are synchronous to aclk.
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module ocs_top #(
    parameter int unsigned TICK_CYCLES = ocs_pkg::TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic link_ok,
    input wire logic prog_mode,
    input wire logic [ocs_pkg::NUM_CH-1:0] cmd_level,
    input wire logic [ocs_pkg::NUM_DIAG-1:0] diag_cond,
    input wire logic prognostic_hit,
    input wire logic [ocs_pkg::NUM_CH-1:0] ch_bad_cond,
    input wire logic [ocs_pkg::NUM_CH-1:0] ch_doubt_cond,
    output logic [ocs_pkg::NUM_CH-1:0] out_level
);
    localparam int N = ocs_pkg::NUM_CH;

    // ==========================================================
    // Declarations
    logic aw_held_reg, w_held_reg;
    logic [ocs_pkg::ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg, bresp_next;
    logic wr_fire;
    logic rvalid_reg;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic rd_fire;

    logic [N-1:0] fault_action_select_reg;
    logic [N-1:0] fault_level_reg;
    logic [N-1:0] prog_action_select_reg;
    logic [N-1:0] prog_level_reg;
    logic [N-1:0] post_timeout_level_reg;
    logic [N-1:0] prog_to_fault_enable_reg;
    logic [7:0] fault_hold_time_reg;

    logic run_state_reg;
    logic link_lost_reg;
    logic diag_active_reg;
    logic [7:0] diag_event_count_reg;
    logic [ocs_pkg::NUM_DIAG-1:0] diag_prev_reg;
    logic diag_change;
    logic [N-1:0] channel_value;
    logic [N-1:0] channel_bad_reg;
    logic [N-1:0] channel_doubtful_reg;

    ocs_pkg::ocs_presc_t presc_reg;
    logic tick;

    // ==========================================================
    // AXI4-Lite write channel
    // Address and data are caught independently; a write lands once
    // both are held and the previous response has been taken.
    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready = !w_held_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (s_axi_awvalid && !aw_held_reg) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr[ocs_pkg::ADDR_W-1:0];
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else if (s_axi_wvalid && !w_held_reg) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    // Unmapped offsets answer SLVERR; read-only offsets accept and ignore
    always_comb begin
        case ({aw_addr_reg[7:2], 2'b00})
            ocs_pkg::OFS_FAULT_ACT, ocs_pkg::OFS_FAULT_LVL,
            ocs_pkg::OFS_PROG_ACT, ocs_pkg::OFS_PROG_LVL,
            ocs_pkg::OFS_POST_LVL, ocs_pkg::OFS_PROG_FLT,
            ocs_pkg::OFS_HOLD_TIME, ocs_pkg::OFS_STATUS,
            ocs_pkg::OFS_CH_VALUE, ocs_pkg::OFS_CH_BAD,
            ocs_pkg::OFS_CH_DOUBT: bresp_next = ocs_pkg::RESP_OKAY;
            default: bresp_next = ocs_pkg::RESP_SLVERR;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= ocs_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= bresp_next;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Configuration registers, byte lane 0 only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_action_select_reg <= ocs_pkg::CFG_RESET;
            fault_level_reg <= ocs_pkg::CFG_RESET;
            prog_action_select_reg <= ocs_pkg::CFG_RESET;
            prog_level_reg <= ocs_pkg::CFG_RESET;
            post_timeout_level_reg <= ocs_pkg::CFG_RESET;
            prog_to_fault_enable_reg <= ocs_pkg::CFG_RESET;
            fault_hold_time_reg <= ocs_pkg::HOLD_RESET;
        end else if (wr_fire && w_strb_reg[0]) begin
            case ({aw_addr_reg[7:2], 2'b00})
                ocs_pkg::OFS_FAULT_ACT: fault_action_select_reg <= w_data_reg[N-1:0];
                ocs_pkg::OFS_FAULT_LVL: fault_level_reg <= w_data_reg[N-1:0];
                ocs_pkg::OFS_PROG_ACT: prog_action_select_reg <= w_data_reg[N-1:0];
                ocs_pkg::OFS_PROG_LVL: prog_level_reg <= w_data_reg[N-1:0];
                ocs_pkg::OFS_POST_LVL: post_timeout_level_reg <= w_data_reg[N-1:0];
                ocs_pkg::OFS_PROG_FLT: prog_to_fault_enable_reg <= w_data_reg[N-1:0];
                ocs_pkg::OFS_HOLD_TIME: fault_hold_time_reg <= w_data_reg[7:0];
                default: fault_hold_time_reg <= fault_hold_time_reg;
            endcase
        end
    end

    // ==========================================================
    // AXI4-Lite read channel
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign rd_fire = s_axi_arvalid && !rvalid_reg;

    // Read mux; unused upper bits read as zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        rresp_next = ocs_pkg::RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'b00})
            ocs_pkg::OFS_FAULT_ACT: rdata_next[N-1:0] = fault_action_select_reg;
            ocs_pkg::OFS_FAULT_LVL: rdata_next[N-1:0] = fault_level_reg;
            ocs_pkg::OFS_PROG_ACT: rdata_next[N-1:0] = prog_action_select_reg;
            ocs_pkg::OFS_PROG_LVL: rdata_next[N-1:0] = prog_level_reg;
            ocs_pkg::OFS_POST_LVL: rdata_next[N-1:0] = post_timeout_level_reg;
            ocs_pkg::OFS_PROG_FLT: rdata_next[N-1:0] = prog_to_fault_enable_reg;
            ocs_pkg::OFS_HOLD_TIME: rdata_next[7:0] = fault_hold_time_reg;
            ocs_pkg::OFS_STATUS: begin
                rdata_next[ocs_pkg::STAT_RUN_BIT] = run_state_reg;
                rdata_next[ocs_pkg::STAT_LOST_BIT] = link_lost_reg;
                rdata_next[ocs_pkg::STAT_DIAG_BIT] = diag_active_reg;
                rdata_next[ocs_pkg::STAT_CNT_LSB +: 8] = diag_event_count_reg;
            end
            ocs_pkg::OFS_CH_VALUE: rdata_next[N-1:0] = channel_value;
            ocs_pkg::OFS_CH_BAD: rdata_next[N-1:0] = channel_bad_reg;
            ocs_pkg::OFS_CH_DOUBT: rdata_next[N-1:0] = channel_doubtful_reg;
            default: rresp_next = ocs_pkg::RESP_SLVERR;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= ocs_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ==========================================================
    // One-second time base
    // restarted while the link is up
    // Held in reset while connected, so the first tick lands exactly
    // one second after the link drops rather than at a random phase.
    always_ff @(posedge aclk) begin
        if (!aresetn || link_ok || tick) begin
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_reg + 1'b1;
        end
    end

    assign tick = !link_ok && (presc_reg == ocs_pkg::ocs_presc_t'(TICK_CYCLES - 1));

    // ==========================================================
    // Connection and mode status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_state_reg <= 1'b0;
            link_lost_reg <= 1'b1;
        end else begin
            run_state_reg <= link_ok && !prog_mode;
            link_lost_reg <= !link_ok;
        end
    end

    // ==========================================================
    // Diagnostics
    assign diag_change = |(diag_cond ^ diag_prev_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            diag_prev_reg <= '0;
            diag_active_reg <= 1'b0;
        end else begin
            diag_prev_reg <= diag_cond;
            diag_active_reg <= (|diag_cond) || prognostic_hit;
        end
    end

    // step on any edge of a condition
    // zero only after reset
    // Several edges in one cycle give a single step; trade for no adder tree.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            diag_event_count_reg <= ocs_pkg::CNT_RESET;
        end else if (diag_change) begin
            if (diag_event_count_reg == ocs_pkg::CNT_MAX) begin
                diag_event_count_reg <= ocs_pkg::CNT_WRAP;
            end else begin
                diag_event_count_reg <= diag_event_count_reg + 8'h01;
            end
        end
    end

    // ==========================================================
    // Channel data quality
    // bad follows cause
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            channel_bad_reg <= '0;
            channel_doubtful_reg <= '0;
        end else begin
            channel_bad_reg <= ch_bad_cond;
            channel_doubtful_reg <= ch_doubt_cond;
        end
    end

    // ==========================================================
    // Channels
    for (genvar i = 0; i < N; i++) begin : g_ch
        ocs_pkg::ocs_cfg_t cfg;
        assign cfg = '{
            fault_action: fault_action_select_reg[i],
            fault_level: fault_level_reg[i],
            prog_action: prog_action_select_reg[i],
            prog_level: prog_level_reg[i],
            post_level: post_timeout_level_reg[i],
            prog_to_fault: prog_to_fault_enable_reg[i]
        };
        ocs_chan u_chan (
            .aclk(aclk),
            .aresetn(aresetn),
            .link_ok(link_ok),
            .prog_mode(prog_mode),
            .cmd_level(cmd_level[i]),
            .tick(tick),
            .hold_time(fault_hold_time_reg),
            .cfg(cfg),
            .out_level(channel_value[i])
        );
    end

    assign out_level = channel_value;

    // ==========================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    link_lost_a: assert property (
        aresetn |=> link_lost_reg == !$past(link_ok))
        else $error("link lost flag wrong");
    diag_active_a: assert property (
        (|diag_cond) || prognostic_hit |=> diag_active_reg)
        else $error("diag active not set");
    diag_step_a: assert property (
        diag_change && diag_event_count_reg != 8'hff
        |=> diag_event_count_reg == $past(diag_event_count_reg) + 8'h01)
        else $error("diag counter did not step");
    diag_wrap_a: assert property (
        diag_change && diag_event_count_reg == 8'hff |=> diag_event_count_reg == 8'h01)
        else $error("diag counter wrap wrong");
    diag_nozero_a: assert property (
        diag_event_count_reg != 8'h00 |=> diag_event_count_reg != 8'h00)
        else $error("diag counter returned to zero");
    value_read_a: assert property (
        rd_fire && s_axi_araddr[7:0] == 8'h20
        |=> rdata_reg[N-1:0] == $past(channel_value))
        else $error("channel value read wrong");
    bad_clear_a: assert property (
        $fell(ch_bad_cond[0]) |=> !channel_bad_reg[0])
        else $error("bad flag did not clear");
    doubt_flag_a: assert property (
        ch_doubt_cond[0] |=> channel_doubtful_reg[0])
        else $error("doubtful flag not set");
    tick_period_a: assert property (
        tick |=> !tick)
        else $error("time base tick too long");

endmodule
`default_nettype wire
